/* verilog/asl_pkg.sv */
package asl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_PRI = 8'h2a;
  localparam logic [7:0] IDX_CTRL_SEC = 8'h2b;
  localparam logic [7:0] IDX_ENABLES = 8'h2c;
  localparam logic [7:0] IDX_STATUS = 8'h2d;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // primary control fields
  localparam int GAIN_HI = 7;
  localparam int GAIN_LO = 5;
  localparam int SYNC_MODE_BIT = 4;
  localparam int AGC_BIT = 3;
  localparam int SYNC_EN_BIT = 2;
  localparam int INSEL_HI = 1;
  localparam int INSEL_LO = 0;
  // secondary control fields
  localparam int AVG_BIT = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int SPEED_HI = 1;
  localparam int SPEED_LO = 0;
  // enables register
  localparam int EXT_SYNC_BIT = 0;
  // reset values
  localparam logic [7:0] RST_CTRL_PRI = 8'h03;
  localparam logic [7:0] RST_CTRL_SEC = 8'h00;
  // codes
  localparam logic [1:0] MODE_LOWER_FREQ = 2'h1;
  localparam logic [1:0] MAP_OVERLAP = 2'h0;
  localparam logic [1:0] MAP_SEPARATE = 2'h1;
  localparam logic [1:0] MAP_ALL = 2'h2;
  localparam logic [1:0] SPD_FASTEST = 2'h0;
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [1:0] SPD_MEDIUM = 2'h2;
  localparam logic [1:0] SPD_SLOW = 2'h3;
  localparam logic [2:0] GAIN_MAX = 3'h7;
  localparam logic [2:0] GAIN_MIN = 3'h0;
  // timing
  localparam longint CORE_CLK_HZ = 125000000;
  localparam longint INT_TICK_HZ = 5000000;
  localparam logic [4:0] INT_TICK_CYC = 5'(CORE_CLK_HZ / INT_TICK_HZ);
  localparam longint SLOW_AMP_MHZ = 3800;
  localparam longint SLOW_FREQ_MHZ = 7600;
  localparam longint SLOW_AMP_CYC_D =
    (CORE_CLK_HZ * 1000 + SLOW_AMP_MHZ - 1) / SLOW_AMP_MHZ;
  localparam longint SLOW_FREQ_CYC_D =
    (CORE_CLK_HZ * 1000 + SLOW_FREQ_MHZ - 1) / SLOW_FREQ_MHZ;
  localparam int PER_W = 26;
  localparam logic [7:0] LVL_THIRD = 8'h55;
  localparam logic [7:0] LVL_TWO_THIRDS = 8'haa;
  localparam logic [7:0] LVL_HALF = 8'h80;

  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} asl_bus_e;
endpackage : asl_pkg

/* verilog/asl_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
module asl_tick_div
  import asl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // period in cycles, 1 means every cycle
  input wire logic [PER_W-1:0] period,
  // one-cycle enable
  output logic tick
);
  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic tick;
  } asl_div_s;

  asl_div_s s_ff;
  asl_div_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    // a shorter period takes effect at once instead of waiting out the old
    if (s_ff.cnt + PER_W'(1) >= period) begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + PER_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule : asl_tick_div
`default_nettype wire

/* verilog/asl_ctrl.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asl_ctrl
  import asl_pkg::*;
#(
  parameter longint SLOW_AMP_CYC = SLOW_AMP_CYC_D,
  parameter longint SLOW_FREQ_CYC = SLOW_FREQ_CYC_D
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // signal path inputs
  input wire logic AGC_RAISE,
  input wire logic AGC_LOWER,
  input wire logic [7:0] PEAK_LEVEL,
  input wire logic [7:0] BAND_LOW,
  input wire logic [7:0] BAND_MID,
  input wire logic [7:0] BAND_HIGH,
  // external timing pin
  input wire logic EXT_SYNC_CLK,
  // signal path controls
  output logic [2:0] GAIN_CODE,
  output logic [1:0] INPUT_ROUTE,
  output logic SYNC_ACTIVE,
  output logic FREQ_MODE,
  output logic FILTER_LOWER,
  output logic AVERAGING_ON,
  // light levels
  output logic [7:0] RED_LEVEL,
  output logic [7:0] GREEN_LEVEL,
  output logic [7:0] BLUE_LEVEL,
  // timing enables
  output logic PATTERN_TICK,
  output logic BOOST_TICK
);
  typedef struct packed {
    asl_bus_e bus;
    logic wait_n;
    logic [7:0] rdata;
    logic [7:0] ctrl_pri;
    logic [7:0] ctrl_sec;
    logic ext_sel;
    logic [2:0] agc_gain;
    logic agc_act;
    logic ext_d;
    logic [4:0] int_cnt;
    logic pat_tick;
    logic boost_tick;
    logic [2:0] gain_code;
    logic [1:0] route;
    logic sync_act;
    logic lower;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } asl_state_s;

  asl_state_s s_ff;
  asl_state_s nxt_s;
  logic upd_tick;
  logic [PER_W-1:0] upd_period;

  // amplitude to light, returns {red, green, blue}
  function automatic logic [23:0] amp_map(input logic [1:0] mode,
                                          input logic [7:0] lvl);
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    r = '0;
    g = '0;
    b = '0;
    unique case (mode)
      MAP_SEPARATE: begin
        if (lvl < LVL_THIRD) begin
          r = lvl;
        end else if (lvl < LVL_TWO_THIRDS) begin
          g = lvl;
        end else begin
          b = lvl;
        end
      end
      MAP_ALL: begin
        r = lvl;
        g = lvl;
        b = lvl;
      end
      // code 11 is unassigned and falls back to the overlapping map
      MAP_OVERLAP, 2'h3: begin
        r = lvl;
        g = (lvl >= LVL_THIRD) ? lvl - LVL_THIRD : '0;
        b = (lvl >= LVL_HALF) ? lvl - LVL_HALF : '0;
      end
    endcase
    return {r, g, b};
  endfunction : amp_map

  // update period per speed; slow caps the rate, fast and medium divide it, fastest is every cycle
  function automatic logic [PER_W-1:0] speed_period(input logic [1:0] spd,
                                                    input logic freq);
    logic [PER_W-1:0] slow;
    slow = freq ? PER_W'(SLOW_FREQ_CYC) : PER_W'(SLOW_AMP_CYC);
    unique case (spd)
      SPD_FASTEST: return PER_W'(1);
      SPD_FAST: return slow >> 2;
      SPD_MEDIUM: return slow >> 1;
      SPD_SLOW: return slow;
    endcase
  endfunction : speed_period

  wire logic freq_mode = s_ff.ctrl_pri[SYNC_MODE_BIT];
  wire logic sync_on = s_ff.ctrl_pri[SYNC_EN_BIT];
  wire logic agc_on = s_ff.ctrl_pri[AGC_BIT];
  wire logic [2:0] man_gain = s_ff.ctrl_pri[GAIN_HI:GAIN_LO];
  wire logic [1:0] mode_ctrl = s_ff.ctrl_sec[MODE_HI:MODE_LO];
  wire logic [7:0] req_idx = AVS_ADDRESS[ADDR_W-1:2];
  wire logic req = AVS_READ | AVS_WRITE;

  assign upd_period = speed_period(s_ff.ctrl_sec[SPEED_HI:SPEED_LO],
                                   freq_mode);

  asl_tick_div u_upd_div (
    .clk(CORE_CLK),
    .rst(RST),
    .period(upd_period),
    .tick(upd_tick)
  );

  always_comb begin
    logic [23:0] amp_rgb;
    logic [7:0] rd;
    amp_rgb = amp_map(mode_ctrl, PEAK_LEVEL);
    rd = '0;
    nxt_s = s_ff;
    // bus: one wait cycle, then the answer stands for one cycle
    unique case (s_ff.bus)
      BUS_IDLE: begin
        if (req) begin
          nxt_s.bus = BUS_ACK;
          unique case (req_idx)
            IDX_CTRL_PRI: rd = s_ff.ctrl_pri;
            IDX_CTRL_SEC: rd = s_ff.ctrl_sec;
            IDX_ENABLES: rd = {7'h00, s_ff.ext_sel};
            IDX_STATUS: rd = {2'h0, s_ff.ext_d, s_ff.agc_gain,
                              s_ff.agc_act, s_ff.sync_act};
            default: rd = '0;
          endcase
          nxt_s.rdata = AVS_READ ? rd : '0;
        end
      end
      BUS_ACK: begin
        nxt_s.bus = BUS_IDLE;
        nxt_s.rdata = '0;
        if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
          unique case (req_idx)
            IDX_CTRL_PRI: nxt_s.ctrl_pri = AVS_WRITEDATA[7:0];
            IDX_CTRL_SEC: nxt_s.ctrl_sec = AVS_WRITEDATA[7:0];
            IDX_ENABLES: nxt_s.ext_sel = AVS_WRITEDATA[EXT_SYNC_BIT];
            default: ;
          endcase
        end
      end
    endcase
    nxt_s.wait_n = (nxt_s.bus == BUS_ACK);

    // automatic gain starts at the manual code, then steps on requests
    nxt_s.agc_act = sync_on & agc_on;
    if (nxt_s.agc_act && !s_ff.agc_act) begin
      nxt_s.agc_gain = man_gain;
    end else if (s_ff.agc_act) begin
      if (AGC_RAISE && !AGC_LOWER && s_ff.agc_gain != GAIN_MAX) begin
        nxt_s.agc_gain = s_ff.agc_gain + 3'h1;
      end else if (AGC_LOWER && !AGC_RAISE && s_ff.agc_gain != GAIN_MIN) begin
        nxt_s.agc_gain = s_ff.agc_gain - 3'h1;
      end
    end
    nxt_s.gain_code = s_ff.agc_act ? s_ff.agc_gain : man_gain;
    nxt_s.route = s_ff.ctrl_pri[INSEL_HI:INSEL_LO];
    nxt_s.sync_act = sync_on;
    nxt_s.lower = freq_mode && (mode_ctrl == MODE_LOWER_FREQ);

    // light levels clear at once while sync is off, otherwise move only on the speed-limited update tick
    if (!sync_on) begin
      nxt_s.red = '0;
      nxt_s.green = '0;
      nxt_s.blue = '0;
    end else if (upd_tick) begin
      if (freq_mode) begin
        nxt_s.red = BAND_LOW;
        nxt_s.blue = BAND_MID;
        nxt_s.green = BAND_HIGH;
      end else begin
        {nxt_s.red, nxt_s.green, nxt_s.blue} = amp_rgb;
      end
    end

    // internal 5 MHz tick; the boost always uses it
    if (s_ff.int_cnt + 5'h1 >= INT_TICK_CYC) begin
      nxt_s.int_cnt = '0;
      nxt_s.boost_tick = 1'b1;
    end else begin
      nxt_s.int_cnt = s_ff.int_cnt + 5'h1;
      nxt_s.boost_tick = 1'b0;
    end
    // pin is sampled at 125 MHz, so it must stay well below half of that
    nxt_s.ext_d = EXT_SYNC_CLK;
    nxt_s.pat_tick = s_ff.ext_sel ? (EXT_SYNC_CLK & ~s_ff.ext_d)
                                  : nxt_s.boost_tick;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_ff <= '0;
      s_ff.bus <= BUS_IDLE;
      s_ff.ctrl_pri <= RST_CTRL_PRI;
      s_ff.ctrl_sec <= RST_CTRL_SEC;
      s_ff.route <= RST_CTRL_PRI[INSEL_HI:INSEL_LO];
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign AVS_READDATA = {24'h000000, s_ff.rdata};
  assign AVS_WAITREQUEST = ~s_ff.wait_n;
  assign GAIN_CODE = s_ff.gain_code;
  assign INPUT_ROUTE = s_ff.route;
  assign SYNC_ACTIVE = s_ff.sync_act;
  assign FREQ_MODE = s_ff.ctrl_pri[SYNC_MODE_BIT];
  assign FILTER_LOWER = s_ff.lower;
  assign AVERAGING_ON = s_ff.ctrl_sec[AVG_BIT];
  assign RED_LEVEL = s_ff.red;
  assign GREEN_LEVEL = s_ff.green;
  assign BLUE_LEVEL = s_ff.blue;
  assign PATTERN_TICK = s_ff.pat_tick;
  assign BOOST_TICK = s_ff.boost_tick;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence seq_agc_start;
    !s_ff.agc_act ##1 s_ff.agc_act;
  endsequence

  a_reset_defaults: assert property (
    $fell(RST) |-> s_ff.ctrl_pri == RST_CTRL_PRI &&
                   s_ff.ctrl_sec == RST_CTRL_SEC)
    else $error("control registers not at defaults after reset");
  a_manual_gain: assert property (
    !s_ff.agc_act |=> GAIN_CODE == $past(man_gain))
    else $error("manual gain not applied");
  a_agc_start_gain: assert property (
    seq_agc_start |-> s_ff.agc_gain == $past(man_gain))
    else $error("automatic gain did not start at manual code");
  a_route_follow: assert property (
    ##1 INPUT_ROUTE == $past(s_ff.ctrl_pri[INSEL_HI:INSEL_LO]))
    else $error("input route does not follow control");
  a_sync_off_dark: assert property (
    !sync_on |=> RED_LEVEL == 8'h00 && GREEN_LEVEL == 8'h00 &&
                 BLUE_LEVEL == 8'h00)
    else $error("lights active while sync disabled");
  a_freq_colours: assert property (
    sync_on && freq_mode && upd_tick |=>
      RED_LEVEL == $past(BAND_LOW) && BLUE_LEVEL == $past(BAND_MID) &&
      GREEN_LEVEL == $past(BAND_HIGH))
    else $error("band to colour mapping wrong");
  a_ext_pattern: assert property (
    s_ff.ext_sel && EXT_SYNC_CLK && !s_ff.ext_d |=> PATTERN_TICK)
    else $error("external edge did not tick pattern timing");
  a_ext_no_int: assert property (
    s_ff.ext_sel && !(EXT_SYNC_CLK && !s_ff.ext_d) |=> !PATTERN_TICK)
    else $error("pattern ticked without external edge");
  a_boost_spacing: assert property (
    BOOST_TICK |=> !BOOST_TICK [*8])
    else $error("boost tick faster than internal rate");
  a_bus_answer: assert property (
    s_ff.bus == BUS_IDLE && req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");
  a_sync_follow: assert property (
    ##1 SYNC_ACTIVE == $past(sync_on))
    else $error("sync active does not follow enable bit");
  a_filter_select: assert property (
    ##1 FILTER_LOWER ==
      ($past(freq_mode) && $past(mode_ctrl) == MODE_LOWER_FREQ))
    else $error("lower filter set not selected as programmed");
  a_agc_step_up: assert property (
    s_ff.agc_act && AGC_RAISE && !AGC_LOWER && s_ff.agc_gain != GAIN_MAX
      |=> s_ff.agc_gain == $past(s_ff.agc_gain) + 3'h1)
    else $error("automatic gain did not step up on request");
  a_auto_gain_out: assert property (
    s_ff.agc_act |=> GAIN_CODE == $past(s_ff.agc_gain))
    else $error("gain output not taken from automatic gain");
  a_amp_overlap: assert property (
    sync_on && !freq_mode && upd_tick && mode_ctrl == MAP_OVERLAP
      |=> RED_LEVEL == $past(PEAK_LEVEL))
    else $error("overlapping map does not pass level to red");
  a_sec_write: assert property (
    s_ff.bus == BUS_ACK && AVS_WRITE && AVS_BYTEENABLE[0] &&
      req_idx == IDX_CTRL_SEC
      |=> s_ff.ctrl_sec == $past(AVS_WRITEDATA[7:0]))
    else $error("secondary control write did not land");
endmodule : asl_ctrl
`default_nettype wire

/* bench/tb_audio_sync_light_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_audio_sync_light_control import asl_pkg::*;;
  logic clk, rst, rd, wr, raise, lower, ext, wreq, fm, fl, avg, act;
  logic ptick, btick;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdat, rdat, q;
  logic [3:0] be;
  logic [7:0] peak, bl, bm, bh, red, grn, blu, p, s, lv;
  logic [2:0] gain;
  logic [1:0] route;
  int n_mismatch, n_checks, cnt, nb, nd, e;

  // short slow periods keep the rate checks within a few hundred cycles
  asl_ctrl #(.SLOW_AMP_CYC(40), .SLOW_FREQ_CYC(20)) asl_ctrl_i (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .AGC_RAISE(raise),
    .AGC_LOWER(lower), .PEAK_LEVEL(peak), .BAND_LOW(bl), .BAND_MID(bm),
    .BAND_HIGH(bh), .EXT_SYNC_CLK(ext), .GAIN_CODE(gain),
    .INPUT_ROUTE(route), .SYNC_ACTIVE(act), .FREQ_MODE(fm),
    .FILTER_LOWER(fl), .AVERAGING_ON(avg), .RED_LEVEL(red),
    .GREEN_LEVEL(grn), .BLUE_LEVEL(blu), .PATTERN_TICK(ptick),
    .BOOST_TICK(btick));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x,
                     input string m);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, g, x);
    end
  endtask : chk

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    addr <= a;
    wdat <= {24'($urandom), d};
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) chk(0, 1, "no answer");
    @(posedge clk);
  endtask : bus

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {i, 2'b00}, d, 4'h1);
  endtask : wreg

  task automatic rdchk(input logic [7:0] i, input logic [7:0] x);
    bus(1'b0, {i, 2'b00}, 8'h00, 4'hf);
    chk(q, {24'h0, x}, "read");
  endtask : rdchk

  function automatic logic [7:0] sub(input logic [7:0] v,
                                     input logic [7:0] k);
    return (v > k) ? v - k : 8'h00;
  endfunction : sub

  // separate thirds map, returns {red, green, blue}
  function automatic logic [23:0] sep(input logic [7:0] v);
    if (v < LVL_THIRD) return {v, 16'h0000};
    if (v < LVL_TWO_THIRDS) return {8'h00, v, 8'h00};
    return {16'h0000, v};
  endfunction : sep

  function automatic int per(input logic f, input logic [1:0] sp);
    int sl;
    sl = f ? 20 : 40;
    case (sp)
      2'h0: return 1;
      2'h1: return sl / 4;
      2'h2: return sl / 2;
      default: return sl;
    endcase
  endfunction : per

  // counts tick pulses; tog drives a 25-cycle square wave on the pin
  task automatic run(input int n, input logic tog);
    cnt = 0;
    nb = 0;
    nd = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (tog) ext <= ((i % 25) >= 13);
      cnt += int'(ptick === 1'b1);
      nb += int'(btick === 1'b1);
      nd += int'(ptick !== btick);
    end
  endtask : run

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {rd, wr, raise, lower, ext} = 5'h00;
    addr = '0;
    wdat = '0;
    be = 4'h0;
    {peak, bl, bm, bh} = 32'h0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(32'he3b460e5));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(route, 2'h3, "route");
    chk({act, fm, avg, gain}, 0, "ctl");
    rdchk(IDX_CTRL_PRI, 8'h03);
    rdchk(IDX_CTRL_SEC, 8'h00);
    bus(1'b1, 10'h3fc, 8'h5a, 4'h1);
    rdchk(8'hff, 8'h00);
    bus(1'b1, {IDX_CTRL_PRI, 2'b00}, 8'hff, 4'h0);
    rdchk(IDX_CTRL_PRI, 8'h03);
    // automatic gain kept off so the manual code shows
    repeat (20) begin
      p = 8'($urandom) & 8'hf7;
      s = 8'($urandom) & 8'h1f;
      raise <= 1'($urandom);
      lower <= 1'($urandom);
      wreg(IDX_CTRL_PRI, p);
      wreg(IDX_CTRL_SEC, s);
      rdchk(IDX_CTRL_PRI, p);
      rdchk(IDX_CTRL_SEC, s);
      chk(gain, p[7:5], "gain");
      chk(route, p[1:0], "route");
      chk({act, fm, avg}, {p[2], p[4], s[4]}, "bits");
      chk(fl, p[4] && s[3:2] == 2'h1, "filt");
    end
    raise <= 1'b0;
    lower <= 1'b0;
    peak <= 8'hff;
    wreg(IDX_CTRL_SEC, 8'h00);
    wreg(IDX_CTRL_PRI, 8'h04);
    @(posedge clk);
    chk(red, 8'hff, "lit");
    wreg(IDX_CTRL_PRI, 8'h00);
    @(posedge clk);
    chk({red, grn, blu}, 0, "off");
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 2; f++) begin
        lv = (m == 0) ? 8'hff : 8'($urandom);
        peak <= lv;
        {bl, bm, bh} <= 24'($urandom);
        wreg(IDX_CTRL_SEC, {4'h0, 2'(m), 2'h0});
        wreg(IDX_CTRL_PRI, {3'h0, 1'(f), 4'h4});
        repeat (3) @(posedge clk);
        if (f == 1) begin
          chk({red, blu, grn}, {bl, bm, bh}, "bands");
          chk(fl, m == 1, "filt");
        end else if (m == 2) begin
          chk({red, grn, blu}, {lv, lv, lv}, "map");
        end else if (m == 1) begin
          chk({red, grn, blu}, sep(lv), "sep");
        end else begin
          chk({red, grn, blu}, {lv, sub(lv, LVL_THIRD),
              sub(lv, LVL_HALF)}, "map");
        end
      end
    end
    // inputs move every cycle, so each update shows as a change
    for (int f = 0; f < 2; f++) begin
      for (int sp = 0; sp < 4; sp++) begin
        wreg(IDX_CTRL_SEC, {6'h0, 2'(sp)});
        wreg(IDX_CTRL_PRI, {3'h0, 1'(f), 4'h4});
        cnt = 0;
        repeat (400) begin
          lv = red;
          @(posedge clk);
          peak <= peak + 8'h01;
          bl <= bl + 8'h01;
          cnt += int'(red !== lv);
        end
        e = 400 / per(1'(f), 2'(sp));
        chk(32'(cnt inside {[e - 1:e + 1]}), 1, "rate");
      end
    end
    wreg(IDX_CTRL_PRI, 8'hac);
    repeat (3) @(posedge clk);
    chk(gain, 3'h5, "agc load");
    raise <= 1'b1;
    repeat (6) @(posedge clk);
    chk(gain, 3'h7, "agc up");
    rdchk(IDX_STATUS, 8'h1f);
    raise <= 1'b0;
    lower <= 1'b1;
    repeat (10) @(posedge clk);
    chk(gain, 3'h0, "agc down");
    lower <= 1'b0;
    wreg(IDX_CTRL_PRI, 8'ha4);
    repeat (3) @(posedge clk);
    chk(gain, 3'h5, "manual");
    wreg(IDX_CTRL_PRI, 8'h4c);
    repeat (3) @(posedge clk);
    chk(gain, 3'h2, "agc reload");
    wreg(IDX_ENABLES, 8'h01);
    run(250, 1'b1);
    chk(32'(cnt inside {[9:11]}), 1, "ext ticks");
    chk(nb, 10, "boost");
    run(100, 1'b0);
    chk(cnt, 0, "ext still");
    wreg(IDX_ENABLES, 8'h00);
    run(250, 1'b1);
    chk(nd, 0, "internal");
    chk(nb, 10, "boost");
    // second reset in mid-run must restore the defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(route, 2'h3, "route");
    rdchk(IDX_CTRL_PRI, 8'h03);
    rdchk(IDX_CTRL_SEC, 8'h00);
    wrap_up();
  end
endmodule : tb_audio_sync_light_control
`default_nettype wire
